/* core/omc_pkg.sv */
// Package for the operating mode control block: offsets, codes, timing.
// Assumes a 25 MHz core clock and an 8-bit register port from the host side.
package omc_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_INIT_KEY  = 8'h0F;
   localparam logic [7:0] OFS_MODE_CTRL = 8'h10;
   localparam logic [7:0] OFS_BURST_LEN = 8'h29;

   localparam logic [7:0] KEY_WRITE     = 8'h42;
   localparam logic [7:0] KEY_STARTING  = 8'h45;
   localparam logic [7:0] KEY_READY     = 8'h40;
   localparam logic [7:0] KEY_ACCEPTED  = 8'h43;
   localparam logic [7:0] MODE_RESET    = 8'h00;
   localparam logic [7:0] BURST_FOREVER = 8'hFF;
   localparam logic [7:0] BURST_NONE    = 8'h00;

   // Mode control field positions
   localparam int SEL_LSB    = 0;
   localparam int SEL_MSB    = 2;
   localparam int X_OFF_BIT  = 4;
   localparam int Y_OFF_BIT  = 5;
   localparam int Z_OFF_BIT  = 6;
   localparam int LAUNCH_BIT = 7;

   // ------------------------------------------------------------
   // Mode select codes
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SEL_SLEEP      = 3'h0,
      SEL_STANDBY    = 3'h1,
      SEL_WATCH      = 3'h2,
      SEL_RSV3       = 3'h3,
      SEL_RSV4       = 3'h4,
      SEL_CONTINUOUS = 3'h5,
      SEL_WATCH_SAMP = 3'h6,
      SEL_BURST      = 3'h7
   } omc_sel_t;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ          = 25_000_000;
   localparam int STATUS_DLY_MS   = 2;
   localparam int STATUS_DLY_CYC  = (CLK_HZ / 1000) * STATUS_DLY_MS;
   localparam int HB_MAX_PERIODS  = 3;
   localparam int HB_DIV          = 16;
   localparam int STARTUP_CYC     = 64;

endpackage : omc_pkg

/* core/omc_hb_if.sv */
// Heartbeat link between the mode core and its heartbeat divider.
// Assumes both ends share one clock.
`timescale 1ns/1ns
interface omc_hb_if;
   logic tick;
   modport src (output tick);
   modport dst (input  tick);
endinterface : omc_hb_if

/* core/omc_heartbeat.sv */
// Heartbeat tick generator pacing mode transitions.
// Assumes a free running core clock; stops ticking when halted (sleep).
`timescale 1ns/1ns
module omc_heartbeat
   import omc_pkg::*;
#(
   parameter int DIV = HB_DIV
)(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Control
   input  wire logic halt,
   // Tick out
   omc_hb_if.src     hb
);

   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } omc_hb_st_t;

   omc_hb_st_t st_ff;
   omc_hb_st_t nxt_st;

   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.tick = 1'b0;
      if (halt)
      begin
         nxt_st.cnt = 16'h0000;
      end
      else if (st_ff.cnt == 16'(DIV - 1))
      begin
         nxt_st.cnt  = 16'h0000;
         nxt_st.tick = 1'b1;
      end
      else
      begin
         nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign hb.tick = st_ff.tick;

endmodule : omc_heartbeat

/* core/omc_pin_sync.sv */
// Two-stage synchroniser with edge select for the event pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ns
module omc_pin_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Pin and control
   input  wire logic pin_n,
   input  wire logic rising,
   // Result
   output logic      edge_seen
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } omc_sync_st_t;

   omc_sync_st_t st_ff;
   omc_sync_st_t nxt_st;

   always_comb
   begin
      nxt_st    = st_ff;
      nxt_st.s1 = pin_n;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
   end

   always_ff @(posedge clk)
   begin
      // Idle pin is high
      if (!rst_n)
         st_ff <= 3'b111;
      else
         st_ff <= nxt_st;
   end

   // Edge looks only at the second and third stages
   assign edge_seen = rising ? (st_ff.s2 & ~st_ff.s3)
                             : (~st_ff.s2 & st_ff.s3);

endmodule : omc_pin_sync

/* core/omc_core.sv */
// Operating mode control: key register, mode control, burst sequencing.
// Assumes a byte-wide register port from the serial interface logic and a
// one-cycle sample strobe and activity flag from the sampling pipeline.
`timescale 1ns/1ns
module omc_core
   import omc_pkg::*;
#(
   parameter int STATUS_DLY = STATUS_DLY_CYC,
   parameter int STARTUP    = STARTUP_CYC
)(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Register port
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // Neighbouring configuration
   input  wire logic [7:0] burst_length,
   input  wire logic       pin_launch_enable,
   input  wire logic       pin_launch_edge,
   // Sampling pipeline
   input  wire logic       sample_done,
   input  wire logic       activity,
   input  wire logic       event_pin_n,
   // Mode outputs
   output logic      [2:0] mode_status,
   output logic            clocks_run,
   output logic            sampling_on,
   output logic            watch_on,
   output logic            fifo_on,
   output logic            x_channel_on,
   output logic            y_channel_on,
   output logic            z_channel_on,
   output logic            keyed
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      KS_START = 3'b001,
      KS_READY = 3'b010,
      KS_KEYED = 3'b100
   } omc_key_t;

   typedef struct packed {
      omc_key_t    key;
      logic [15:0] boot_cnt;
      logic [2:0]  select_field;
      logic        x_channel_off;
      logic        y_channel_off;
      logic        z_channel_off;
      logic [2:0]  active_mode;
      logic [1:0]  hb_cnt;
      logic        pending;
      logic [2:0]  shown_mode;
      logic [31:0] show_cnt;
      logic        show_busy;
      logic        bursting;
      logic [7:0]  burst_left;
      logic        burst_forever;
      logic        armed;
      logic [7:0]  rdata;
   } omc_st_t;

   omc_st_t st_ff;
   omc_st_t nxt_st;

   logic    hb_tick;
   logic    pin_edge;
   logic    mode_wr;
   logic    launch;

   omc_hb_if hb_link ();

   // Heartbeat stops in sleep unless a mode change is pending
   omc_heartbeat #(.DIV(HB_DIV)) u_hb (
      .clk   (clk),
      .rst_n (rst_n),
      .halt  (st_ff.active_mode == SEL_SLEEP && !st_ff.pending),
      .hb    (hb_link)
   );
   assign hb_tick = hb_link.tick;

   omc_pin_sync u_pin (
      .clk       (clk),
      .rst_n     (rst_n),
      .pin_n     (event_pin_n),
      .rising    (pin_launch_edge),
      .edge_seen (pin_edge)
   );

   function automatic logic is_sampling(input logic [2:0] m);
      return m == SEL_CONTINUOUS || m == SEL_WATCH_SAMP || m == SEL_BURST;
   endfunction : is_sampling

   assign mode_wr = reg_wr && reg_addr == OFS_MODE_CTRL;
   // Launch honoured only from standby; pin launches also wait until the
   // pending switch to standby has landed
   assign launch  = st_ff.active_mode == SEL_STANDBY
                    && ((mode_wr && reg_wdata[LAUNCH_BIT])
                        || (pin_launch_enable && st_ff.armed
                            && pin_edge && !st_ff.pending));

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;

      // Key register status
      unique case (st_ff.key)
         KS_START:
         begin
            if (st_ff.boot_cnt == 16'(STARTUP - 1))
               nxt_st.key = KS_READY;
            else
               nxt_st.boot_cnt = st_ff.boot_cnt + 16'h0001;
         end
         KS_READY:
         begin
            if (reg_wr && reg_addr == OFS_INIT_KEY && reg_wdata == KEY_WRITE)
               nxt_st.key = KS_KEYED;
         end
         KS_KEYED:
         begin
            nxt_st.key = KS_KEYED;
         end
      endcase

      // Host writes to mode control
      if (mode_wr)
      begin
         nxt_st.x_channel_off = reg_wdata[X_OFF_BIT];
         nxt_st.y_channel_off = reg_wdata[Y_OFF_BIT];
         nxt_st.z_channel_off = reg_wdata[Z_OFF_BIT];
         if (!reg_wdata[LAUNCH_BIT])
         begin
            nxt_st.select_field = reg_wdata[SEL_MSB:SEL_LSB];
            nxt_st.pending      = 1'b1;
            nxt_st.hb_cnt       = 2'h0;
            // Pin-launched burst waits in standby until the edge
            nxt_st.armed = reg_wdata[SEL_MSB:SEL_LSB] == SEL_BURST
                           && pin_launch_enable;
         end
      end

      // Apply on a heartbeat, bounded by HB_MAX_PERIODS
      if (st_ff.pending && hb_tick)
      begin
         if (st_ff.hb_cnt == 2'(HB_MAX_PERIODS - 1)
             || st_ff.select_field != st_ff.active_mode)
         begin
            nxt_st.pending     = 1'b0;
            nxt_st.active_mode = st_ff.armed ? 3'(SEL_STANDBY)
                                             : st_ff.select_field;
            nxt_st.show_busy   = 1'b1;
            nxt_st.show_cnt    = 32'h0;
            nxt_st.bursting    = st_ff.select_field == SEL_BURST
                                 && !st_ff.armed;
            nxt_st.burst_left    = burst_length;
            nxt_st.burst_forever = burst_length == BURST_FOREVER;
         end
         else
            nxt_st.hb_cnt = st_ff.hb_cnt + 2'h1;
      end

      // Launch a burst from standby
      if (launch)
      begin
         nxt_st.select_field  = SEL_BURST;
         nxt_st.active_mode   = SEL_BURST;
         nxt_st.bursting      = 1'b1;
         nxt_st.armed         = 1'b0;
         nxt_st.pending       = 1'b0;
         nxt_st.burst_left    = burst_length;
         nxt_st.burst_forever = burst_length == BURST_FOREVER;
         nxt_st.show_busy     = 1'b1;
         nxt_st.show_cnt      = 32'h0;
      end
      else if (st_ff.bursting && sample_done && !st_ff.burst_forever)
      begin
         if (st_ff.burst_left <= 8'h01)
         begin
            nxt_st.bursting     = 1'b0;
            nxt_st.active_mode  = SEL_STANDBY;
            nxt_st.select_field = SEL_STANDBY;
            nxt_st.show_busy    = 1'b1;
            nxt_st.show_cnt     = 32'h0;
         end
         else
            nxt_st.burst_left = st_ff.burst_left - 8'h01;
      end

      // Activity wakes watch mode into continuous sampling
      if (!mode_wr && !st_ff.pending && activity
          && st_ff.active_mode == SEL_WATCH)
      begin
         nxt_st.active_mode  = SEL_CONTINUOUS;
         nxt_st.select_field = SEL_CONTINUOUS;
         nxt_st.show_busy    = 1'b1;
         nxt_st.show_cnt     = 32'h0;
      end

      // Status follows the active mode after the settle delay; a restart
      // in this cycle wins over the count running out
      if (st_ff.show_busy && nxt_st.show_cnt == st_ff.show_cnt)
      begin
         if (st_ff.show_cnt == 32'(STATUS_DLY - 1))
         begin
            nxt_st.show_busy  = 1'b0;
            nxt_st.shown_mode = st_ff.active_mode;
         end
         else
            nxt_st.show_cnt = st_ff.show_cnt + 32'h1;
      end

      // Read data: key register reads status, not the value written
      nxt_st.rdata = 8'h00;
      if (reg_rd && reg_addr == OFS_INIT_KEY)
      begin
         unique case (st_ff.key)
            KS_START: nxt_st.rdata = KEY_STARTING;
            KS_READY: nxt_st.rdata = KEY_READY;
            KS_KEYED: nxt_st.rdata = KEY_ACCEPTED;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_ff            <= '0;
         st_ff.key        <= KS_START;
         st_ff.burst_left <= BURST_NONE;
      end
      else
         st_ff <= nxt_st;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata    = st_ff.rdata;
   assign mode_status  = st_ff.shown_mode;
   assign keyed        = st_ff.key == KS_KEYED;
   assign clocks_run   = st_ff.active_mode != SEL_SLEEP;
   assign sampling_on  = is_sampling(st_ff.active_mode)
                         && (st_ff.active_mode != SEL_BURST
                             || st_ff.bursting);
   assign watch_on     = st_ff.active_mode == SEL_WATCH
                         || st_ff.active_mode == SEL_WATCH_SAMP;
   assign fifo_on      = st_ff.active_mode != SEL_WATCH && sampling_on;
   assign x_channel_on = sampling_on && !st_ff.x_channel_off;
   assign y_channel_on = sampling_on && !st_ff.y_channel_off;
   assign z_channel_on = sampling_on && !st_ff.z_channel_off;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Worst case: three heartbeats plus the cycle that applies the change
   localparam int HB_WAIT = HB_MAX_PERIODS * HB_DIV + 1;

   sequence key_read;
      reg_rd && reg_addr == OFS_INIT_KEY;
   endsequence

   sequence key_written;
      st_ff.key == KS_READY && reg_wr && reg_addr == OFS_INIT_KEY
      && reg_wdata == KEY_WRITE;
   endsequence

   chk_key_start: assert property (
      reg_rd && reg_addr == OFS_INIT_KEY && st_ff.key == KS_START
      |=> reg_rdata == KEY_STARTING)
      else $error("key not 0x45 during start-up");
   chk_key_ready: assert property (
      reg_rd && reg_addr == OFS_INIT_KEY && st_ff.key == KS_READY
      |=> reg_rdata == KEY_READY)
      else $error("key not 0x40 after start-up");
   chk_key_done: assert property (
      key_written |=> st_ff.key == KS_KEYED)
      else $error("key write not accepted");
   chk_key_read: assert property (
      key_read ##0 st_ff.key == KS_KEYED |=> reg_rdata == KEY_ACCEPTED)
      else $error("key not 0x43 after key write");
   chk_mode_apply: assert property (
      mode_wr && !reg_wdata[LAUNCH_BIT]
      |=> ##[0:HB_WAIT] (!st_ff.pending || mode_wr))
      else $error("mode change not applied in time");
   chk_sleep_clk: assert property (
      st_ff.active_mode == SEL_SLEEP |-> !clocks_run && !sampling_on)
      else $error("clocks run in sleep");
   chk_watch_wake: assert property (
      st_ff.active_mode == SEL_WATCH && activity && !mode_wr
      && !st_ff.pending |=> st_ff.active_mode == SEL_CONTINUOUS
      && st_ff.select_field == SEL_CONTINUOUS)
      else $error("activity did not wake watch mode");
   chk_cont_nowatch: assert property (
      st_ff.active_mode == SEL_CONTINUOUS |-> sampling_on && !watch_on)
      else $error("continuous mode wrong");
   chk_ws_all: assert property (
      st_ff.active_mode == SEL_WATCH_SAMP |-> watch_on && sampling_on
      && fifo_on)
      else $error("watch and sample not all on");
   chk_axis_off: assert property (
      st_ff.x_channel_off |-> !x_channel_on)
      else $error("x channel on while off");
   chk_launch_only: assert property (
      mode_wr && reg_wdata[LAUNCH_BIT] && st_ff.active_mode != SEL_STANDBY
      && !launch |=> !$rose(st_ff.bursting))
      else $error("burst launched outside standby");
   chk_burst_end: assert property (
      st_ff.bursting && !st_ff.burst_forever && sample_done && !launch
      && st_ff.burst_left == 8'h01 |=> st_ff.active_mode == SEL_STANDBY)
      else $error("burst did not return to standby");

endmodule : omc_core

/* dv/test_omc_core.sv */
// Self-checking bench for the operating mode control core.
// Assumes the core alone; neighbour inputs are driven from here.
`timescale 1ns/1ns
module test_omc_core;
   import omc_pkg::*;

   // ------------------------------------------------------------
   // Settings and signals
   // ------------------------------------------------------------
   // Short counts keep the run brief; bounds derive from them
   localparam int SDLY  = 20;
   localparam int START = 8;
   localparam int HBW   = HB_MAX_PERIODS * HB_DIV + 4;
   localparam int LIMIT = 6000;
   localparam int S_CLK = 0;
   localparam int S_SMP = 1;

   logic       clk;
   logic       rst_n;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [7:0] burst_length;
   logic       pin_launch_enable;
   logic       pin_launch_edge;
   logic       sample_done;
   logic       activity;
   logic       event_pin_n;
   logic [2:0] mode_status;
   logic       clocks_run;
   logic       sampling_on;
   logic       watch_on;
   logic       fifo_on;
   logic       x_channel_on;
   logic       y_channel_on;
   logic       z_channel_on;
   logic       keyed;
   int         errors = 0;
   int         samples_checked = 0;
   int         cycles = 0;
   logic [7:0] codes [3] = '{8'h55, 8'h26, 8'h02};
   logic       exp_s [3] = '{1'b1, 1'b1, 1'b0};
   logic       exp_w [3] = '{1'b0, 1'b1, 1'b1};
   logic       exp_f [3] = '{1'b1, 1'b1, 1'b0};

   omc_core #(.STATUS_DLY(SDLY), .STARTUP(START)) dut (
      .clk(clk), .rst_n(rst_n),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .burst_length(burst_length),
      .pin_launch_enable(pin_launch_enable),
      .pin_launch_edge(pin_launch_edge),
      .sample_done(sample_done), .activity(activity),
      .event_pin_n(event_pin_n), .mode_status(mode_status),
      .clocks_run(clocks_run), .sampling_on(sampling_on),
      .watch_on(watch_on), .fifo_on(fifo_on),
      .x_channel_on(x_channel_on), .y_channel_on(y_channel_on),
      .z_channel_on(z_channel_on), .keyed(keyed)
   );

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles >= LIMIT)
      begin
         errors++;
         stop_test();
      end
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic check8(input string n, input logic [7:0] e,
                         input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : check8

   task automatic check3(input string n, input logic [2:0] e,
                         input logic [2:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : check3

   task automatic check1(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("unexpected %s expected %b seen %b", n, e, g);
      end
   endtask : check1

   function automatic logic sig(input int s);
      return (s == S_CLK) ? clocks_run : sampling_on;
   endfunction : sig

   task automatic wait_sig(input string n, input int s, input logic v,
                           input int lim);
      int k;
      k = 0;
      while (sig(s) !== v && k < lim)
      begin
         @(posedge clk);
         #2;
         k++;
      end
      check1(n, v, sig(s));
   endtask : wait_sig

   task automatic wait_mode(input logic [2:0] v, input int lim);
      int k;
      k = 0;
      while (mode_status !== v && k < lim)
      begin
         @(posedge clk);
         #2;
         k++;
      end
      check3("mode_status", v, mode_status);
   endtask : wait_mode

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #2;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #2;
      reg_wr = 1'b0;
   endtask : reg_write

   // Data stands one cycle only, so it is taken right after the edge
   task automatic read_check(input string n, input logic [7:0] a,
                             input logic [7:0] e);
      @(posedge clk);
      #2;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #2;
      reg_rd = 1'b0;
      check8(n, e, reg_rdata);
   endtask : read_check

   task automatic pulses(input int n);
      repeat (n)
      begin
         @(posedge clk);
         #2;
         sample_done = 1'b1;
         @(posedge clk);
         #2;
         sample_done = 1'b0;
      end
   endtask : pulses

   task automatic pin_set(input logic v);
      @(posedge clk);
      #2;
      event_pin_n = v;
   endtask : pin_set

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      burst_length = 8'h03;
      pin_launch_enable = 1'b0;
      pin_launch_edge = 1'b0;
      sample_done = 1'b0;
      activity = 1'b0;
      event_pin_n = 1'b1;
      repeat (3) @(posedge clk);
      #2;
      rst_n = 1'b1;
      read_check("key start-up", OFS_INIT_KEY, KEY_STARTING);
      repeat (START) @(posedge clk);
      read_check("key ready", OFS_INIT_KEY, KEY_READY);
      reg_write(OFS_INIT_KEY, 8'h55);
      read_check("key wrong value", OFS_INIT_KEY, KEY_READY);
      reg_write(OFS_INIT_KEY, KEY_WRITE);
      read_check("key accepted", OFS_INIT_KEY, KEY_ACCEPTED);
      check1("keyed", 1'b1, keyed);
      read_check("unmapped read", 8'h20, 8'h00);
      reg_write(OFS_MODE_CTRL, 8'h01);
      wait_sig("standby clocks", S_CLK, 1'b1, HBW);
      check3("status lag", 3'h0, mode_status);
      wait_mode(3'h1, SDLY + 4);
      check1("standby sampling", 1'b0, sampling_on);
      for (int i = 0; i < 3; i++)
      begin
         reg_write(OFS_MODE_CTRL, codes[i]);
         wait_mode(codes[i][2:0], HBW + SDLY + 4);
         check1("sampling_on", exp_s[i], sampling_on);
         check1("watch_on", exp_w[i], watch_on);
         check1("fifo_on", exp_f[i], fifo_on);
         if (exp_s[i])
         begin
            check1("x on", ~codes[i][X_OFF_BIT], x_channel_on);
            check1("y on", ~codes[i][Y_OFF_BIT], y_channel_on);
            check1("z on", ~codes[i][Z_OFF_BIT], z_channel_on);
         end
      end
      @(posedge clk);
      #2;
      activity = 1'b1;
      @(posedge clk);
      #2;
      activity = 1'b0;
      wait_sig("wake sampling", S_SMP, 1'b1, 4);
      check1("wake watch off", 1'b0, watch_on);
      wait_mode(SEL_CONTINUOUS, SDLY + 4);
      reg_write(OFS_MODE_CTRL, 8'h01);
      wait_mode(3'h1, HBW + SDLY + 4);
      reg_write(OFS_MODE_CTRL, 8'h81);
      wait_sig("burst on", S_SMP, 1'b1, 4);
      pulses(2);
      check1("burst mid", 1'b1, sampling_on);
      pulses(1);
      wait_sig("burst end", S_SMP, 1'b0, 4);
      check1("burst back standby", 1'b1, clocks_run);
      burst_length = BURST_FOREVER;
      reg_write(OFS_MODE_CTRL, 8'h81);
      wait_sig("endless on", S_SMP, 1'b1, 4);
      pulses(8);
      check1("endless still on", 1'b1, sampling_on);
      reg_write(OFS_MODE_CTRL, 8'h01);
      wait_sig("endless stop", S_SMP, 1'b0, HBW);
      reg_write(OFS_MODE_CTRL, 8'h00);
      wait_sig("sleep clocks", S_CLK, 1'b0, HBW);
      reg_write(OFS_MODE_CTRL, 8'h80);
      repeat (HBW) @(posedge clk);
      check1("launch refused", 1'b0, sampling_on);
      check1("sleep kept", 1'b0, clocks_run);
      reg_write(OFS_MODE_CTRL, 8'h01);
      wait_sig("standby again", S_CLK, 1'b1, HBW);
      pin_launch_enable = 1'b1;
      burst_length = 8'h02;
      reg_write(OFS_MODE_CTRL, 8'h07);
      repeat (HBW) @(posedge clk);
      check1("armed idle", 1'b0, sampling_on);
      pin_set(1'b0);
      wait_sig("pin fall launch", S_SMP, 1'b1, 6);
      pulses(2);
      wait_sig("pin burst end", S_SMP, 1'b0, 4);
      pin_set(1'b1);
      pin_launch_edge = 1'b1;
      reg_write(OFS_MODE_CTRL, 8'h07);
      repeat (HBW) @(posedge clk);
      pin_set(1'b0);
      repeat (8) @(posedge clk);
      check1("fall ignored", 1'b0, sampling_on);
      pin_set(1'b1);
      wait_sig("pin rise launch", S_SMP, 1'b1, 6);
      pulses(2);
      wait_sig("rise burst end", S_SMP, 1'b0, 4);
      // Second reset in mid-run must restore start-up key state
      @(posedge clk);
      #2;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #2;
      rst_n = 1'b1;
      check3("status after reset", 3'h0, mode_status);
      check1("keyed after reset", 1'b0, keyed);
      read_check("key restart", OFS_INIT_KEY, KEY_STARTING);
      stop_test();
   end

endmodule : test_omc_core
